/* File: logic/urxce_rx.sv */
// Receive side of one asynchronous serial channel: filter, frame, buffer,
// error flags and completion/error interrupts.
// Assumes i_fuclk_en is a one-cycle pulse from a prescaler on i_mclk and
// that the baud divisor only changes while reception is disabled.
`timescale 1ns/1ps
`default_nettype none
module urxce_rx
    import urxce_pkg::*;
#(
    parameter int unsigned DATA_BITS = DATA_BITS_DEF
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_reset,
    // Configuration
    input wire logic i_unit_enable_bit,
    input wire logic i_receive_enable_bit,
    input wire logic i_error_irq_routing_bit,
    input wire logic [1:0] i_parity_mode,
    input wire logic [7:0] i_baud_div,
    input wire logic i_fuclk_en,
    // Serial line
    input wire logic i_serial_rx_input,
    // Receive buffer stream
    output logic o_rx_valid,
    output logic [DATA_BITS-1:0] o_rx_data,
    input wire logic i_rx_ready,
    // Status
    input wire logic i_status_read,
    output logic [2:0] o_rx_status,
    // Interrupts
    output logic o_rx_done_irq,
    output logic o_rx_error_irq
);
    if (DATA_BITS < 5 || DATA_BITS > 8) begin : g_bad_width
        $error("DATA_BITS must lie between 5 and 8");
    end

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic samp;
        logic filt;
        logic filt_prev;
        urxce_state_e state;
        logic [8:0] cnt;
        logic [3:0] bitn;
        logic [DATA_BITS-1:0] shift;
        logic par_err;
        logic [2:0] status;
        logic [DATA_BITS-1:0] head;
        logic head_v;
        logic [DATA_BITS-1:0] tail;
        logic tail_v;
        logic done_irq;
        logic err_irq;
    } urxce_state_s;

    urxce_state_s q;
    urxce_state_s d;

    // Parity bit a transmitter would send for this data
    function automatic logic tx_parity(input logic [DATA_BITS-1:0] data,
                                       input logic [1:0] mode);
        case (mode)
            PAR_EVEN: tx_parity = ^data;
            PAR_ODD: tx_parity = ~^data;
            default: tx_parity = 1'b0;
        endcase
    endfunction

    logic tick;
    logic bit_end;
    logic [8:0] half_end;
    logic frame_err;
    logic ovr;

    always_comb begin
        d = q;
        d.done_irq = 1'b0;
        d.err_irq = 1'b0;
        frame_err = 1'b0;
        ovr = 1'b0;
        // Basic clock stands still with the unit disabled
        tick = i_fuclk_en & i_unit_enable_bit;
        half_end = {1'b0, i_baud_div} - 9'h001;
        bit_end = (q.cnt == ({i_baud_div, 1'b0} - 9'h001));
        d.sync1 = i_serial_rx_input;
        d.sync2 = q.sync1;
        // Two equal samples before the filtered line moves
        if (tick) begin
            d.samp = q.sync2;
            if (q.sync2 == q.samp) begin
                d.filt = q.sync2;
            end
        end
        d.filt_prev = q.filt;
        // Consumer pops the head; tail slides forward
        if (i_rx_ready && q.head_v) begin
            if (q.tail_v) begin
                d.head = q.tail;
                d.tail_v = 1'b0;
            end else begin
                d.head_v = 1'b0;
            end
        end
        if (i_status_read) begin
            d.status = STATUS_RST;
        end
        if (!i_receive_enable_bit) begin
            d.state = URXCE_IDLE;
            // A parity error of the cut frame must not reach the next one
            d.par_err = 1'b0;
        end else begin
            case (q.state)
                URXCE_IDLE: begin
                    if (q.filt_prev && !q.filt) begin
                        d.state = URXCE_START;
                        d.cnt = 9'h000;
                    end
                end
                URXCE_START: begin
                    if (tick) begin
                        if (q.cnt == half_end) begin
                            d.cnt = 9'h000;
                            d.bitn = 4'h0;
                            // A glitch that is gone by mid bit is no start
                            d.state = q.filt ? URXCE_IDLE :
                                URXCE_DATA;
                        end else begin
                            d.cnt = q.cnt + 9'h001;
                        end
                    end
                end
                URXCE_DATA: begin
                    if (tick) begin
                        if (bit_end) begin
                            d.cnt = 9'h000;
                            d.shift = {q.filt,
                                q.shift[DATA_BITS-1:1]};
                            d.bitn = q.bitn + 4'h1;
                            if (q.bitn == 4'(DATA_BITS - 1)) begin
                                d.state = (i_parity_mode == PAR_NONE) ?
                                    URXCE_STOP : URXCE_PARITY;
                            end
                        end else begin
                            d.cnt = q.cnt + 9'h001;
                        end
                    end
                end
                URXCE_PARITY: begin
                    if (tick) begin
                        if (bit_end) begin
                            d.cnt = 9'h000;
                            d.state = URXCE_STOP;
                            // Mismatch equals a wrong ones count overall
                            d.par_err = (i_parity_mode == PAR_EVEN ||
                                i_parity_mode == PAR_ODD) &&
                                (q.filt != tx_parity(q.shift,
                                i_parity_mode));
                        end else begin
                            d.cnt = q.cnt + 9'h001;
                        end
                    end
                end
                URXCE_STOP: begin
                    if (tick) begin
                        if (bit_end) begin
                            d.state = URXCE_IDLE;
                            d.cnt = 9'h000;
                            frame_err = !q.filt;
                            ovr = d.head_v && d.tail_v;
                            if (!ovr) begin
                                // Errored frames are still delivered
                                if (!d.head_v) begin
                                    d.head = q.shift;
                                    d.head_v = 1'b1;
                                end else begin
                                    d.tail = q.shift;
                                    d.tail_v = 1'b1;
                                end
                            end
                            // Set wins over a read in the same cycle
                            d.status[ST_PARITY] = d.status[ST_PARITY] |
                                q.par_err;
                            d.status[ST_FRAMING] = d.status[ST_FRAMING] |
                                frame_err;
                            d.status[ST_OVERRUN] = d.status[ST_OVERRUN] |
                                ovr;
                            if ((q.par_err || frame_err || ovr) &&
                                !i_error_irq_routing_bit) begin
                                d.err_irq = 1'b1;
                            end else begin
                                d.done_irq = 1'b1;
                            end
                            d.par_err = 1'b0;
                        end else begin
                            d.cnt = q.cnt + 9'h001;
                        end
                    end
                end
                default: d.state = URXCE_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            q <= '0;
            q.sync1 <= 1'b1;
            q.sync2 <= 1'b1;
            q.samp <= 1'b1;
            q.filt <= 1'b1;
            q.filt_prev <= 1'b1;
            q.state <= URXCE_IDLE;
            q.status <= STATUS_RST;
            q.head <= DATA_BITS'(BUF_RST);
        end else begin
            q <= d;
        end
    end

    assign o_rx_valid = q.head_v;
    assign o_rx_data = q.head;
    assign o_rx_status = q.status;
    assign o_rx_done_irq = q.done_irq;
    assign o_rx_error_irq = q.err_irq;

    property p_done_needs_en;
        @(posedge i_mclk) disable iff (i_reset)
        o_rx_done_irq |-> $past(i_receive_enable_bit);
    endproperty
    a_done_needs_en: assert property (p_done_needs_en)
        else $error("done interrupt while reception disabled");

    property p_err_needs_en;
        @(posedge i_mclk) disable iff (i_reset)
        o_rx_error_irq |-> $past(i_receive_enable_bit);
    endproperty
    a_err_needs_en: assert property (p_err_needs_en)
        else $error("error interrupt while reception disabled");

    property p_irq_exclusive;
        @(posedge i_mclk) disable iff (i_reset)
        !(o_rx_done_irq && o_rx_error_irq);
    endproperty
    a_irq_exclusive: assert property (p_irq_exclusive)
        else $error("both interrupts for one frame");

    property p_err_route;
        @(posedge i_mclk) disable iff (i_reset)
        o_rx_error_irq |-> !$past(i_error_irq_routing_bit);
    endproperty
    a_err_route: assert property (p_err_route)
        else $error("error interrupt with routing bit set");

    property p_err_flags;
        @(posedge i_mclk) disable iff (i_reset)
        o_rx_error_irq |-> (o_rx_status != 3'h0);
    endproperty
    a_err_flags: assert property (p_err_flags)
        else $error("error interrupt without a status flag");

    property p_read_clears;
        @(posedge i_mclk) disable iff (i_reset)
        $past(i_status_read) && !o_rx_done_irq && !o_rx_error_irq
            |-> o_rx_status == 3'h0;
    endproperty
    a_read_clears: assert property (p_read_clears)
        else $error("status not cleared by read");

    property p_abort;
        @(posedge i_mclk) disable iff (i_reset)
        !i_receive_enable_bit |=> q.state == URXCE_IDLE && !o_rx_done_irq &&
            !o_rx_error_irq;
    endproperty
    a_abort: assert property (p_abort)
        else $error("reception not aborted");

    property p_filter;
        @(posedge i_mclk) disable iff (i_reset)
        $changed(q.filt) |-> $past(q.samp) == q.filt && $past(tick);
    endproperty
    a_filter: assert property (p_filter)
        else $error("filter moved without two equal samples");

    property p_overrun_keeps;
        @(posedge i_mclk) disable iff (i_reset)
        $past(q.head_v && q.tail_v && !i_rx_ready) &&
            (o_rx_done_irq || o_rx_error_irq)
            |-> o_rx_data == $past(o_rx_data) && o_rx_status[ST_OVERRUN];
    endproperty
    a_overrun_keeps: assert property (p_overrun_keeps)
        else $error("overrun changed the buffer or missed its flag");
endmodule
`default_nettype wire

/* File: logic/urxce_pkg.sv */
// Constants and types shared by the receive completion and error block.
// Assumes one 20 MHz clock and a basic clock enable from a prescaler.
package urxce_pkg;
    localparam int unsigned MCLK_HZ = 20000000;
    // Filter lag in basic clocks: two equal samples before a change
    localparam int unsigned FILTER_LAG_CLK = 2;
    localparam int unsigned DATA_BITS_DEF = 8;
    localparam logic [7:0] BAUD_DIV_MIN = 8'h08;
    // Parity mode encoding on the mode input
    localparam logic [1:0] PAR_NONE = 2'h0;
    localparam logic [1:0] PAR_ZERO = 2'h1;
    localparam logic [1:0] PAR_ODD = 2'h2;
    localparam logic [1:0] PAR_EVEN = 2'h3;
    // Status flag positions and reset value
    localparam int unsigned ST_OVERRUN = 0;
    localparam int unsigned ST_FRAMING = 1;
    localparam int unsigned ST_PARITY = 2;
    localparam logic [2:0] STATUS_RST = 3'h0;
    localparam logic [7:0] BUF_RST = 8'h00;
    typedef enum logic [2:0] {
        URXCE_IDLE,
        URXCE_START,
        URXCE_DATA,
        URXCE_PARITY,
        URXCE_STOP
    } urxce_state_e;
endpackage

/* File: verif/urxce_tx_model.sv */
// Remote asynchronous transmitter model on the serial receive line.
// Assumes the basic clock ticks every mclk cycle; bit time given in cycles.
`timescale 1ns/1ps
`default_nettype none
module urxce_tx_model
    import urxce_pkg::*;
(
    // Clock
    input wire logic i_mclk,
    // Serial line
    output logic o_line
);
    initial o_line = 1'b1;

    task automatic put(input logic v, input int cyc);
        @(negedge i_mclk);
        o_line = v;
        repeat (cyc - 1) @(negedge i_mclk);
    endtask

    // Corrupt parity or stop only when a scenario asks for it
    task automatic send(input logic [7:0] data, input logic [1:0] mode,
                        input logic bad_par, input logic bad_stop,
                        input int bitc);
        logic par;
        par = ^data;
        if (mode == PAR_ODD) par = ~par;
        if (mode == PAR_ZERO) par = 1'b0;
        par = par ^ bad_par;
        put(1'b0, bitc);
        for (int i = 0; i < 8; i++) put(data[i], bitc);
        if (mode != PAR_NONE) put(par, bitc);
        put(~bad_stop, bitc);
        // Idle line rests high between frames
        put(1'b1, 2 * bitc);
    endtask

    task automatic glitch(input int bitc);
        put(1'b0, 1);
        put(1'b1, 4 * bitc);
    endtask
endmodule
`default_nettype wire

/* File: verif/tb_uart_rx_completion_errors.sv */
// Self-checking bench for the receive completion and error block.
// Assumes the basic clock enable is held high, so one bit is 2*k cycles.
`timescale 1ns/1ps
`default_nettype none
module tb_uart_rx_completion_errors;
    import urxce_pkg::*;
    localparam int K = 8;
    localparam int BITC = 2 * K;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic unit_en = 1'b1;
    logic rx_en = 1'b1;
    logic route = 1'b0;
    logic [1:0] pmode = PAR_NONE;
    logic fuclk_en = 1'b1;
    logic ready = 1'b0;
    logic st_read = 1'b0;
    wire logic line;
    logic valid;
    logic [7:0] data;
    logic [2:0] status;
    logic [2:0] st_irq;
    logic done;
    logic err;
    int n_errors = 0;
    int total_checks = 0;
    int n_done = 0;
    int n_err = 0;

    always #25 mclk = ~mclk;

    // Pulses are counted at the falling edge, where they have settled;
    // an unknown pulse counts, so that expected-zero checks catch it
    always @(negedge mclk) begin
        if (done !== 1'b0) n_done++;
        if (err !== 1'b0) n_err++;
        if (done || err) st_irq = status;
    end

    urxce_tx_model u_tx (.i_mclk(mclk), .o_line(line));

    urxce_rx #(.DATA_BITS(8)) DUT (
        .i_mclk(mclk), .i_reset(reset), .i_unit_enable_bit(unit_en),
        .i_receive_enable_bit(rx_en), .i_error_irq_routing_bit(route),
        .i_parity_mode(pmode), .i_baud_div(8'h08), .i_fuclk_en(fuclk_en),
        .i_serial_rx_input(line), .o_rx_valid(valid), .o_rx_data(data),
        .i_rx_ready(ready), .i_status_read(st_read), .o_rx_status(status),
        .o_rx_done_irq(done), .o_rx_error_irq(err));

    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic frame(input logic [7:0] d, input logic bp, input logic bs);
        n_done = 0;
        n_err = 0;
        u_tx.send(d, pmode, bp, bs, BITC);
    endtask

    task automatic irqs(input int d, input int e, input logic [2:0] st);
        chk("done irq count", d[7:0], n_done[7:0]);
        chk("error irq count", e[7:0], n_err[7:0]);
        if (d + e > 0) chk("status at irq", {5'h0, st}, {5'h0, st_irq});
    endtask

    task automatic rd_status(input logic [2:0] exp);
        @(negedge mclk);
        chk("status before read", {5'h0, exp}, {5'h0, status});
        st_read = 1'b1;
        @(negedge mclk);
        st_read = 1'b0;
        chk("status after read", 8'h00, {5'h0, status});
    endtask

    task automatic pop(input logic [7:0] exp);
        @(negedge mclk);
        chk("valid", 8'h01, {7'h0, valid});
        chk("data", exp, data);
        ready = 1'b1;
        @(negedge mclk);
        ready = 1'b0;
    endtask

    task automatic t_parity();
        logic e;
        for (int m = 0; m < 4; m++) begin
            pmode = m[1:0];
            e = (pmode == PAR_ODD) || (pmode == PAR_EVEN);
            frame(8'h07, 1'b0, 1'b0);
            irqs(1, 0, 3'h0);
            pop(8'h07);
            frame(8'h07, 1'b1, 1'b0);
            irqs(e ? 0 : 1, e ? 1 : 0, e ? 3'h4 : 3'h0);
            rd_status(e ? 3'h4 : 3'h0);
            pop(8'h07);
        end
        $display("parity modes test done");
    endtask

    task automatic t_framing();
        route = 1'b1;
        pmode = PAR_NONE;
        frame(8'h3c, 1'b0, 1'b1);
        irqs(1, 0, 3'h2);
        rd_status(3'h2);
        pop(8'h3c);
        route = 1'b0;
        $display("framing test done");
    endtask

    task automatic t_overrun();
        pmode = PAR_EVEN;
        frame(8'h11, 1'b0, 1'b0);
        frame(8'h22, 1'b0, 1'b0);
        irqs(1, 0, 3'h0);
        frame(8'h33, 1'b0, 1'b0);
        irqs(0, 1, 3'h1);
        rd_status(3'h1);
        pop(8'h11);
        pop(8'h22);
        @(negedge mclk);
        chk("valid after drain", 8'h00, {7'h0, valid});
        chk("data kept", 8'h22, data);
        $display("overrun test done");
    endtask

    task automatic t_abort();
        n_done = 0;
        n_err = 0;
        fork
            u_tx.send(8'h55, pmode, 1'b0, 1'b0, BITC);
            begin
                repeat (5 * BITC) @(negedge mclk);
                rx_en = 1'b0;
            end
        join
        irqs(0, 0, 3'h0);
        chk("valid after abort", 8'h00, {7'h0, valid});
        chk("status after abort", 8'h00, {5'h0, status});
        frame(8'h66, 1'b1, 1'b1);
        irqs(0, 0, 3'h0);
        chk("status disabled", 8'h00, {5'h0, status});
        rx_en = 1'b1;
        frame(8'h77, 1'b0, 1'b0);
        irqs(1, 0, 3'h0);
        pop(8'h77);
        $display("abort test done");
    endtask

    task automatic t_noise();
        n_done = 0;
        n_err = 0;
        u_tx.glitch(BITC);
        irqs(0, 0, 3'h0);
        chk("valid after glitch", 8'h00, {7'h0, valid});
        // Two-cycle pulse passes the filter but is gone by mid start bit
        u_tx.put(1'b0, 2);
        u_tx.put(1'b1, 4 * BITC);
        irqs(0, 0, 3'h0);
        chk("valid after short start", 8'h00, {7'h0, valid});
        unit_en = 1'b0;
        frame(8'h5a, 1'b1, 1'b0);
        irqs(0, 0, 3'h0);
        chk("valid unit off", 8'h00, {7'h0, valid});
        chk("status unit off", 8'h00, {5'h0, status});
        unit_en = 1'b1;
        $display("noise test done");
    endtask

    initial begin
        repeat (100000) @(posedge mclk);
        n_errors++;
        finish_test();
    end

    initial begin
        repeat (10) @(negedge mclk);
        reset = 1'b0;
        repeat (2) @(negedge mclk);
        t_parity();
        t_framing();
        t_overrun();
        t_abort();
        t_noise();
        finish_test();
    end
endmodule
`default_nettype wire
